// file: csr_pkg.sv
// Constants and types for the controller status read formatter.
// Assumes a single 20 MHz clock domain and word-wide request and response areas.
`default_nettype none
package csr_pkg;
    localparam logic [15:0] CSR_SEQ_EVENT    = 16'h00fa;
    localparam logic [15:0] CSR_SEQ_TIMESIG  = 16'h00fb;
    localparam logic [15:0] CSR_SEQ_ERRGRP   = 16'h00fc;
    localparam logic [15:0] CSR_OFS_TOTAL    = 16'h0000;
    localparam logic [15:0] CSR_OFS_UNITS    = 16'h0001;
    localparam logic [15:0] CSR_OFS_FIRST    = 16'h0002;
    localparam logic [15:0] CSR_OFS_RSP_HEAD = 16'h0000;
    localparam logic [6:0]  CSR_REQ_EXTRA    = 7'h02;
    localparam logic [6:0]  CSR_MAX_UNITS_ST = 7'h19;
    localparam logic [6:0]  CSR_MAX_UNITS_EG = 7'h08;
    localparam logic [6:0]  CSR_MAX_UNIT_NO  = 7'h1f;
    localparam logic [3:0]  CSR_WPU_ST       = 4'h5;
    localparam logic [3:0]  CSR_WPU_EG       = 4'h8;
    localparam logic [3:0]  CSR_BCD_MAX      = 4'h9;
    localparam logic [7:0]  CSR_HUNDRED      = 8'h64;
    localparam logic [7:0]  CSR_TEN          = 8'h0a;

    typedef enum logic [1:0] {CSR_K_EVENT, CSR_K_TIMESIG, CSR_K_ERRGRP} csr_kind_e;
    typedef enum logic [2:0] {CSR_S_IDLE, CSR_S_TOTAL, CSR_S_COUNT, CSR_S_SCAN,
                              CSR_S_HEAD, CSR_S_UNIT, CSR_S_ASK} csr_state_e;
endpackage
`default_nettype wire

// file: csr_formatter.sv
// Request parser and response packer for event, time-signal and error-group reads.
// Assumes request words readable combinationally and a controller port with ack handshake.
// Overview of operation
// - Request words are read from the send area base and results written from the receive area base word 0.
// - Sequence 250 reads events, 251 reads time signals and 252 reads error groups.
// - An event read writes response word 0 as BCD five times the units plus one.
// - Each unit gets five response words holding events 1 to 10, two bytes per word.
// - A time-signal read writes response word 0 as BCD five times the units plus one.
// - Each unit gets five response words holding time signals 1 to 10, two bytes per word.
// - An error-group read writes response word 0 as BCD eight times the units plus one.
// - Each unit gets eight consecutive words holding error groups 0 to 15, next unit following at once.
`default_nettype none
module csr_formatter
    import csr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic [15:0] seq_num,
    input  wire logic [15:0] req_base,
    input  wire logic [15:0] rsp_base,
    output logic      [15:0] req_addr,
    input  wire logic [15:0] req_data,
    output logic             rsp_we,
    output logic      [15:0] rsp_addr,
    output logic      [15:0] rsp_data,
    output logic             ctl_req,
    output logic      [1:0]  ctl_kind,
    output logic      [4:0]  ctl_unit,
    output logic      [3:0]  ctl_item,
    input  wire logic        ctl_ack,
    input  wire logic [7:0]  ctl_data,
    output logic             busy,
    output logic             done,
    output logic             error
);
    csr_state_e  state;
    csr_kind_e   kind;
    logic [15:0] req_base_q;
    logic [15:0] rsp_base_q;
    logic [6:0]  total;
    logic [6:0]  units;
    logic [6:0]  uidx;
    logic [7:0]  rsp_ptr;
    logic [3:0]  item;
    logic [7:0]  hi_byte;

    // One BCD decoder serves every request word
    wire         word_ok   = (req_data[15:8] == 8'h00) && (req_data[7:4] <= CSR_BCD_MAX)
                             && (req_data[3:0] <= CSR_BCD_MAX);
    wire  [6:0]  word_bin  = (7'(req_data[7:4]) * 7'd10) + 7'(req_data[3:0]);
    wire  [6:0]  max_units = (kind == CSR_K_ERRGRP) ? CSR_MAX_UNITS_EG : CSR_MAX_UNITS_ST;
    wire  [3:0]  wpu       = (kind == CSR_K_ERRGRP) ? CSR_WPU_EG : CSR_WPU_ST;
    wire  [3:0]  last_item = 4'({wpu, 1'b0} - 5'd1);
    wire         last_unit = (uidx == units - 7'd1);
    wire  [7:0]  tot_words = (8'(units) * 8'(wpu)) + 8'd1;
    wire         hund      = (tot_words >= CSR_HUNDRED);
    wire  [7:0]  rem_words = hund ? 8'(tot_words - CSR_HUNDRED) : tot_words;
    wire  [3:0]  tens_dig  = 4'(rem_words / CSR_TEN);
    wire  [3:0]  ones_dig  = 4'(rem_words % CSR_TEN);
    wire  [15:0] head_bcd  = {7'h00, hund, tens_dig, ones_dig};
    wire         count_ok  = word_ok && (word_bin != 7'h00) && (word_bin <= max_units)
                             && (total == word_bin + CSR_REQ_EXTRA);
    wire         unit_ok   = word_ok && (word_bin <= CSR_MAX_UNIT_NO);
    wire         seq_ok    = (seq_num == CSR_SEQ_EVENT) || (seq_num == CSR_SEQ_TIMESIG)
                             || (seq_num == CSR_SEQ_ERRGRP);
    wire         take      = (state == CSR_S_ASK) && ctl_ack;
    wire  [15:0] unit_ofs  = CSR_OFS_FIRST + 16'(uidx);

    assign req_addr = (state == CSR_S_TOTAL) ? req_base_q + CSR_OFS_TOTAL :
                      (state == CSR_S_COUNT) ? req_base_q + CSR_OFS_UNITS :
                      req_base_q + unit_ofs;
    assign ctl_req  = (state == CSR_S_ASK);
    assign ctl_kind = kind;
    assign ctl_item = (kind == CSR_K_ERRGRP) ? item : item + 4'd1;
    assign busy     = (state != CSR_S_IDLE);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state      <= CSR_S_IDLE;
            kind       <= CSR_K_EVENT;
            req_base_q <= 16'h0000;
            rsp_base_q <= 16'h0000;
            total      <= 7'h00;
            units      <= 7'h00;
            uidx       <= 7'h00;
            rsp_ptr    <= 8'h00;
            item       <= 4'h0;
            hi_byte    <= 8'h00;
            ctl_unit   <= 5'h00;
            rsp_we     <= 1'b0;
            rsp_addr   <= 16'h0000;
            rsp_data   <= 16'h0000;
            done       <= 1'b0;
            error      <= 1'b0;
        end else begin
            rsp_we <= 1'b0;
            done   <= 1'b0;
            error  <= 1'b0;
            case (state)
                CSR_S_IDLE: begin
                    if (start) begin
                        req_base_q <= req_base;
                        rsp_base_q <= rsp_base;
                        if (!seq_ok) begin
                            error <= 1'b1;
                        end else begin
                            state <= CSR_S_TOTAL;
                            kind  <= (seq_num == CSR_SEQ_EVENT)   ? CSR_K_EVENT :
                                     (seq_num == CSR_SEQ_TIMESIG) ? CSR_K_TIMESIG : CSR_K_ERRGRP;
                        end
                    end
                end
                CSR_S_TOTAL: begin
                    total <= word_bin;
                    state <= word_ok ? CSR_S_COUNT : CSR_S_IDLE;
                    error <= !word_ok;
                end
                CSR_S_COUNT: begin
                    // Count must match word 0 before any unit is touched
                    units <= word_bin;
                    uidx  <= 7'h00;
                    state <= count_ok ? CSR_S_SCAN : CSR_S_IDLE;
                    error <= !count_ok;
                end
                CSR_S_SCAN: begin
                    // Whole list checked first so a bad entry leaves the response area untouched
                    if (!unit_ok) begin
                        state <= CSR_S_IDLE;
                        error <= 1'b1;
                    end else if (last_unit) begin
                        state <= CSR_S_HEAD;
                    end else begin
                        uidx <= uidx + 7'd1;
                    end
                end
                CSR_S_HEAD: begin
                    rsp_we   <= 1'b1;
                    rsp_addr <= rsp_base_q + CSR_OFS_RSP_HEAD;
                    rsp_data <= head_bcd;
                    rsp_ptr  <= 8'h01;
                    uidx     <= 7'h00;
                    state    <= CSR_S_UNIT;
                end
                CSR_S_UNIT: begin
                    ctl_unit <= word_bin[4:0];
                    item     <= 4'h0;
                    state    <= CSR_S_ASK;
                end
                CSR_S_ASK: begin
                    if (take) begin
                        item <= item + 4'd1;
                        if (!item[0]) begin
                            hi_byte <= ctl_data;
                        end else begin
                            rsp_we   <= 1'b1;
                            rsp_addr <= rsp_base_q + 16'(rsp_ptr);
                            rsp_data <= {hi_byte, ctl_data};
                            rsp_ptr  <= rsp_ptr + 8'd1;
                        end
                        if (item == last_item) begin
                            if (last_unit) begin
                                state <= CSR_S_IDLE;
                                done  <= 1'b1;
                            end else begin
                                uidx  <= uidx + 7'd1;
                                state <= CSR_S_UNIT;
                            end
                        end
                    end
                end
                default: state <= CSR_S_IDLE;
            endcase
        end
    end

    property p_head_addr;
        @(posedge clk) disable iff (rst)
        (state == CSR_S_HEAD) |=> rsp_we && (rsp_addr == rsp_base_q);
    endproperty
    a_head_addr: assert property (p_head_addr) else $error("head word not at response base");

    property p_seq_kind;
        @(posedge clk) disable iff (rst)
        (state == CSR_S_IDLE && start && seq_num == CSR_SEQ_ERRGRP) |=> kind == CSR_K_ERRGRP && state == CSR_S_TOTAL;
    endproperty
    a_seq_kind: assert property (p_seq_kind) else $error("sequence 252 not decoded");

    property p_total_match;
        @(posedge clk) disable iff (rst)
        (state == CSR_S_COUNT && word_ok && total != word_bin + CSR_REQ_EXTRA) |=> error && state == CSR_S_IDLE;
    endproperty
    a_total_match: assert property (p_total_match) else $error("bad request word count accepted");

    property p_eg_limit;
        @(posedge clk) disable iff (rst)
        (state == CSR_S_COUNT && kind == CSR_K_ERRGRP && word_ok && word_bin > CSR_MAX_UNITS_EG) |=> error;
    endproperty
    a_eg_limit: assert property (p_eg_limit) else $error("too many error-group units accepted");

    property p_unit_latch;
        @(posedge clk) disable iff (rst)
        (state == CSR_S_UNIT) |=> state == CSR_S_ASK
            && ctl_unit == $past(req_data[3:0]) + 5'(10 * $past(req_data[7:4]));
    endproperty
    a_unit_latch: assert property (p_unit_latch) else $error("unit number not decoded");

    property p_evt_head;
        @(posedge clk) disable iff (rst)
        (state == CSR_S_HEAD && kind == CSR_K_EVENT && units == 7'd25) |=> rsp_data == 16'h0126;
    endproperty
    a_evt_head: assert property (p_evt_head) else $error("event header count wrong");

    property p_ts_head;
        @(posedge clk) disable iff (rst)
        (state == CSR_S_HEAD && kind == CSR_K_TIMESIG && units == 7'd1) |=> rsp_data == 16'h0006;
    endproperty
    a_ts_head: assert property (p_ts_head) else $error("time-signal header count wrong");

    property p_eg_head;
        @(posedge clk) disable iff (rst)
        (state == CSR_S_HEAD && kind == CSR_K_ERRGRP && units == 7'd8) |=> rsp_data == 16'h0065;
    endproperty
    a_eg_head: assert property (p_eg_head) else $error("error-group header count wrong");

    property p_item_span;
        @(posedge clk) disable iff (rst)
        ctl_req |-> (kind == CSR_K_ERRGRP) ? (ctl_item <= 4'd15) : (ctl_item >= 4'd1 && ctl_item <= 4'd10);
    endproperty
    a_item_span: assert property (p_item_span) else $error("item number out of range");

    property p_word_total;
        @(posedge clk) disable iff (rst)
        done |-> rsp_ptr == tot_words;
    endproperty
    a_word_total: assert property (p_word_total) else $error("response word count differs from header");

    property p_pack;
        @(posedge clk) disable iff (rst)
        (take && item[0]) |=> rsp_we && rsp_data == {$past(hi_byte), $past(ctl_data)};
    endproperty
    a_pack: assert property (p_pack) else $error("byte pair packed wrongly");

    property p_no_write_on_error;
        @(posedge clk) disable iff (rst)
        (state == CSR_S_SCAN && !unit_ok) |=> error && !rsp_we ##1 !rsp_we;
    endproperty
    a_no_write_on_error: assert property (p_no_write_on_error) else $error("write after bad unit");
endmodule // csr_formatter
`default_nettype wire

// file: csr_ctl_model.sv
// Behavioural model of the addressed controllers on the far side.
// Assumes the formatter holds ctl_req and its qualifiers until ctl_ack.
`default_nettype none
module csr_ctl_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       slow,
    input  wire logic       ctl_req,
    input  wire logic [1:0] ctl_kind,
    input  wire logic [4:0] ctl_unit,
    input  wire logic [3:0] ctl_item,
    output logic            ctl_ack,
    output logic      [7:0] ctl_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wait_cnt;
    logic [7:0] last;
    // Unit bit 4 folded in so units 15 and 31 answer differently
    wire  [7:0] item_val = {ctl_item, ctl_unit[3:0]} + {ctl_kind, ctl_unit[4], 5'h00};
    assign ctl_ack  = ctl_req && (wait_cnt >= (slow ? 2'h3 : 2'h0));
    // Stale data is inverted so a late sample never matches
    assign ctl_data = ctl_ack ? item_val : ~last;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_cnt <= 2'h0;
            last     <= 8'h00;
        end else begin
            wait_cnt <= (ctl_req && !ctl_ack) ? wait_cnt + 2'h1 : 2'h0;
            last     <= ctl_ack ? item_val : last;
        end
    end
endmodule // csr_ctl_model
`default_nettype wire

// file: tb_controller_status_read_formatter.sv
// Self-checking bench for the status read formatter.
// Assumes the controller model answers with a byte made from kind, unit and item.
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_controller_status_read_formatter;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, start = 0, slow = 0;
    logic [15:0] seq_num = 16'h0000, req_addr, rsp_addr, rsp_data;
    logic [15:0] req_base = 16'h0010, rsp_base = 16'h0080;
    logic rsp_we, ctl_req, ctl_ack, busy, done, error;
    logic [1:0] ctl_kind;
    logic [4:0] ctl_unit;
    logic [3:0] ctl_item;
    logic [7:0] ctl_data;
    logic [15:0] mem [0:255];
    logic [15:0] rsp [0:255];
    int num_errors = 0, comparisons = 0, nwr = 0;
    int ubin [0:31];
    always #25 clk = ~clk;
    wire [15:0] req_data_w;
    assign req_data_w = mem[req_addr[7:0]];
    csr_formatter DUT (.clk(clk), .rst(rst), .start(start), .seq_num(seq_num), .req_base(req_base),
        .rsp_base(rsp_base), .req_addr(req_addr), .req_data(req_data_w), .rsp_we(rsp_we),
        .rsp_addr(rsp_addr), .rsp_data(rsp_data), .ctl_req(ctl_req), .ctl_kind(ctl_kind),
        .ctl_unit(ctl_unit), .ctl_item(ctl_item), .ctl_ack(ctl_ack), .ctl_data(ctl_data),
        .busy(busy), .done(done), .error(error));
    csr_ctl_model ctl (.clk(clk), .rst(rst), .slow(slow), .ctl_req(ctl_req), .ctl_kind(ctl_kind),
        .ctl_unit(ctl_unit), .ctl_item(ctl_item), .ctl_ack(ctl_ack), .ctl_data(ctl_data));
    always @(posedge clk) begin
        if (rsp_we) begin
            rsp[rsp_addr[7:0]] <= rsp_data;
            nwr <= nwr + 1;
        end
    end
    function automatic logic [15:0] bcd(input int v);
        return {4'(v / 1000), 4'((v / 100) % 10), 4'((v / 10) % 10), 4'(v % 10)};
    endfunction
    task automatic setu(input int i, input int u);
        mem[req_base[7:0] + 2 + i] = bcd(u);
        ubin[i] = u;
    endtask
    // Shared request: count words, unit count, then start pulse and judge the answer
    task automatic run(input logic [15:0] seq, input int n, input int nreq, input bit bad);
        int wpu, base, k, t, w0;
        logic [7:0] hi, lo;
        mem[req_base[7:0]] = bcd(nreq);
        mem[req_base[7:0] + 1] = bcd(n);
        w0 = nwr;
        @(posedge clk) start <= 1'b1;
        seq_num <= seq;
        @(posedge clk) start <= 1'b0;
        // A bad sequence errors in this very cycle
        #1;
        `CHK(busy, seq >= 16'h00fa && seq <= 16'h00fc)
        t = 0;
        while (!(done === 1'b1 || error === 1'b1) && t < 5000) begin
            @(posedge clk);
            #1 t++;
        end
        `CHK(error, bad)
        `CHK(done, !bad)
        `CHK(busy, 1'b0)
        @(posedge clk);
        #1;
        `CHK(done | error, 1'b0)
        if (bad) begin
            `CHK(nwr - w0, 0)
            return;
        end
        wpu  = (seq == 16'h00fc) ? 8 : 5;
        base = (seq == 16'h00fc) ? 0 : 1;
        k    = int'(seq[1:0]) - 2;
        `CHK(nwr - w0, wpu * n + 1)
        `CHK(rsp[rsp_base[7:0]], bcd(wpu * n + 1))
        for (int i = 0; i < n; i++) begin
            for (int w = 0; w < wpu; w++) begin
                hi = {4'(2 * w + base), 4'(ubin[i])} + {2'(k), 1'(ubin[i] / 16), 5'h00};
                lo = {4'(2 * w + base + 1), 4'(ubin[i])} + {2'(k), 1'(ubin[i] / 16), 5'h00};
                `CHK(rsp[rsp_base[7:0] + 1 + i * wpu + w], {hi, lo})
            end
        end
    endtask
    task automatic t_event_slow();
        slow = 1'b1;
        setu(0, 5);
        setu(1, 31);
        run(16'h00fa, 2, 4, 1'b0);
        slow = 1'b0;
    endtask
    task automatic t_time_one();
        // Moved areas, so fixed offsets cannot hide the base handling
        @(posedge clk);
        req_base <= 16'h0040;
        rsp_base <= 16'h00c0;
        @(posedge clk);
        setu(0, 0);
        run(16'h00fb, 1, 3, 1'b0);
        @(posedge clk);
        req_base <= 16'h0010;
        rsp_base <= 16'h0080;
        @(posedge clk);
    endtask
    task automatic t_errgrp_max();
        for (int i = 0; i < 8; i++) setu(i, 3 * i + 7);
        run(16'h00fc, 8, 10, 1'b0);
    endtask
    task automatic t_event_max();
        for (int i = 0; i < 25; i++) setu(i, 24 - i);
        run(16'h00fa, 25, 27, 1'b0);
    endtask
    // Each refusal must raise error and leave the receive area untouched
    task automatic t_refusals();
        setu(0, 2);
        run(16'h00fc, 9, 11, 1'b1);
        run(16'h00fb, 26, 28, 1'b1);
        run(16'h00fa, 0, 2, 1'b1);
        run(16'h00fd, 1, 3, 1'b1);
        run(16'h00fa, 1, 4, 1'b1);
        setu(0, 32);
        run(16'h00fa, 1, 3, 1'b1);
        mem[18] = 16'h001a;
        run(16'h00fb, 1, 3, 1'b1);
    endtask
    task automatic finish_test();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors++;
        finish_test();
    end
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_event_slow();
        t_time_one();
        t_errgrp_max();
        t_event_max();
        t_refusals();
        finish_test();
    end
endmodule // tb_controller_status_read_formatter
`default_nettype wire
